// ===== rta_pkg.sv
// shared constants for the tamper and auxiliary output block
package rta_pkg;
	localparam int NUM_TAMP = 3;              // tamper channels in the full variant
	localparam int BKP_WORDS = 32;            // backup words kept
	localparam int BKP_W = 32;                // width of one backup word
	localparam int BKP_AW = 5;                // backup word index width
	localparam int FILT_CW = 4;               // filter match counter width
	localparam int SAMP_W = 9;                // sample timer width
	localparam logic [1:0] FILT_EDGE = 2'h0;  // filter field value for edge mode
	localparam logic [3:0] FILT_ONE = 4'h1;   // base of the 2/4/8 sample target
	localparam logic [SAMP_W-1:0] SAMP_SLOW = 9'h100; // slowest sample period
	localparam logic [SAMP_W-1:0] PRCH_ONE = 9'h001;  // base of precharge length
	localparam logic [1:0] ALARM_OUTPUT_SELECT_OFF = 2'h0;   // alarm output inactive
	localparam logic [1:0] ALARM_OUTPUT_SELECT_ALRA = 2'h1;  // alarm a flag selected
	localparam logic [1:0] ALARM_OUTPUT_SELECT_ALRB = 2'h2;  // alarm b flag selected
	localparam logic [1:0] ALARM_OUTPUT_SELECT_WKUP = 2'h3;  // wakeup timer flag selected
	localparam logic DRIVE_OD = 1'b0;         // open-drain drive type code
	localparam int CAL_ASYNC_TAP = 5;         // async counter bit giving clock/64
	localparam int CAL_SYNC_TAP = 7;          // sync counter bit giving /256 stage
endpackage

// ===== rta_chan_if.sv
// per-channel carrier between the block top and one tamper channel
`timescale 1ns/1ns
interface rta_chan_if;
	logic       enable;      // channel enable after variant gating
	logic       trigger;     // trigger polarity, 0 active high
	logic [1:0] filt;        // filter field, 0 for edge mode
	logic       sample_tick; // filtered-mode sample strobe
	logic       event_p;     // one-cycle tamper event
	logic       active;      // debounced pin at its active level
	modport ctrl (output enable, trigger, filt, sample_tick, input event_p, active);
	modport chan (input enable, trigger, filt, sample_tick, output event_p, active);
endinterface

// ===== rta_tamper_chan.sv
// one tamper channel: pin synchroniser, edge and filtered level detection
`timescale 1ns/1ns
module rta_tamper_chan
	import rta_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic clk_en_in,
	input  wire logic pin_in,
	rta_chan_if.chan  ch
);
	import rta_pkg::*;

	logic [2:0]         sync_q;     // three-stage pin synchroniser
	logic [3:0]         warm_q;     // fill marker, level is a guess until bit 3
	logic               level;      // accepted pin level
	logic               gated_q;    // previous enabled-active value
	logic [FILT_CW-1:0] match_cnt;  // consecutive matching samples
	logic               next_event; // detection this cycle
	logic               next_act;   // active level at the current level
	logic               gated;      // active level anded with enable
	logic [FILT_CW-1:0] target;     // samples needed: 2, 4 or 8

	// level only moves when stages two and three agree
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			sync_q <= 3'h0;
			level <= 1'b0;
			warm_q <= 4'h0;
		end
		else if (clk_en_in)
		begin
			warm_q <= {warm_q[2:0], 1'b1};
			sync_q <= {sync_q[1:0], pin_in}; // [RULE23]
			if (sync_q[1] == sync_q[2])
				level <= sync_q[2]; // [RULE23]
		end
	end

	// trigger 0 is active high, trigger 1 active low
	assign next_act = ch.trigger ? ~level : level;
	// enable gating makes an already-active pin fire on enable
	// held off until the synchroniser is full, so reset cannot fake an edge
	assign gated = next_act & ch.enable & warm_q[3]; // [RULE8]
	assign target = FILT_CW'(FILT_ONE << ch.filt); // [RULE10]

	// event decision for both modes
	always_comb
	begin
		if (ch.filt == FILT_EDGE)
			next_event = gated & ~gated_q; // [RULE7]
		else
			next_event = ch.sample_tick & gated && (match_cnt == target - FILT_ONE);
	end

	// edge history and sample match counter
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			gated_q <= 1'b0;
			match_cnt <= '0;
			ch.event_p <= 1'b0;
		end
		else if (clk_en_in)
		begin
			gated_q <= gated;
			ch.event_p <= next_event;
			if (ch.filt == FILT_EDGE || !gated)
				match_cnt <= '0;
			// saturating at target stops a held level refiring
			else if (ch.sample_tick && match_cnt != target)
				match_cnt <= match_cnt + FILT_ONE; // [RULE10]
		end
	end

	assign ch.active = next_act;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_EDGE_FIRE: assert property ( // [RULE8]
		clk_en_in && ch.filt == FILT_EDGE && gated && !gated_q |=> ch.event_p)
		else $error("edge mode missed an enabled active level");
	AST_FILT_RESET: assert property ( // [RULE10]
		clk_en_in && ch.filt != FILT_EDGE && !gated |=> !ch.event_p && match_cnt == 0)
		else $error("filter fired or kept count on a mismatch");
	COV_EDGE: cover property (ch.filt == FILT_EDGE && ch.event_p);
	COV_FILT: cover property (ch.filt != FILT_EDGE && ch.event_p);
endmodule

// ===== rta_top.sv
// tamper detection, backup words, calibration and alarm output on one pin
// Operation
// (RULE1) three tamper inputs, small variant one edge-only
// (RULE2) backup words survive all but power-on or tamper
// (RULE3) any tamper event clears every backup word
// (RULE4) per-input enable and flag, set on event
// (RULE5) irq enable raises interrupt on tamper event
// (RULE6) tamper may timestamp; flags set same cycle
// (RULE7) filter zero: edge detect, polarity per input
// (RULE8) edge signal gated by enable, fires if active
// (RULE9) software re-enables input before rewriting backups
// (RULE10) filtered mode needs 2, 4 or 8 matches
// (RULE11) pull-up precharge before samples unless disabled
// (RULE12) sample rate field sets sampling interval
// (RULE13) calibration clock is kernel clock over 64
// (RULE14) calibration output ignores smooth calibration value
// (RULE15) select set: kernel over 256 times prescaler
// (RULE16) one hertz output irregular during shift pending
// (RULE17) alarm output picks alarm a, b, wakeup
// (RULE18) polarity bit inverts the alarm output
// (RULE19) drive type picks open-drain or push-pull
// (RULE20) selected output forces shared pin to output
// (RULE21) software keeps calibration off when using alarm
// (RULE22) events signal low-power exit on slow clock
// (RULE23) tamper pins synchronised before evaluation
`timescale 1ns/1ns
module rta_top
	import rta_pkg::*;
(
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	input  wire logic                clk_en_in,
	input  wire logic [NUM_TAMP-1:0] tamper_pin_in,
	input  wire logic                single_input_variant_in,
	input  wire logic [NUM_TAMP-1:0] tamper_input_enable_in,
	input  wire logic [NUM_TAMP-1:0] tamper_trigger_polarity_in,
	input  wire logic [1:0]          tamper_filter_count_in,
	input  wire logic                tamper_pullup_disable_in,
	input  wire logic [1:0]          tamper_precharge_duration_in,
	input  wire logic [2:0]          tamper_sample_rate_in,
	input  wire logic                tamper_irq_enable_in,
	input  wire logic                timestamp_on_tamper_in,
	input  wire logic [NUM_TAMP-1:0] tamper_flag_clear_in,
	input  wire logic                timestamp_event_in,
	input  wire logic                timestamp_flag_clear_in,
	input  wire logic                bkp_wr_en_in,
	input  wire logic [BKP_AW-1:0]   bkp_addr_in,
	input  wire logic [BKP_W-1:0]    bkp_wdata_in,
	input  wire logic                cal_output_enable_in,
	input  wire logic                cal_output_select_in,
	input  wire logic [6:0]          async_prescaler_in,
	input  wire logic [7:0]          sync_prescaler_low_in,
	input  wire logic                shift_pending_flag_in,
	input  wire logic [1:0]          alarm_output_select_in,
	input  wire logic                alarm_output_polarity_in,
	input  wire logic                alarm_output_drive_type_in,
	input  wire logic                alarm_a_flag_in,
	input  wire logic                alarm_b_flag_in,
	input  wire logic                wakeup_timer_flag_in,
	input  wire logic                low_speed_clock_source_in,
	output logic [NUM_TAMP-1:0]      tamper_flag_out,
	output logic                     tamper_irq_out,
	output logic                     timestamp_flag_out,
	output logic                     timestamp_overflow_flag_out,
	output logic [NUM_TAMP-1:0]      tamper_pullup_out,
	output logic [BKP_W-1:0]         bkp_rdata_out,
	output logic                     shared_function_pin_out,
	output logic                     shared_function_pin_oe_out,
	output logic                     low_power_exit_out
);
	import rta_pkg::*;

	logic [NUM_TAMP-1:0] chan_en;      // enables after variant gating
	logic [1:0]          filt_eff;     // filter field after variant gating
	logic [NUM_TAMP-1:0] tamp_event;   // per-channel event pulses
	logic                any_event;    // any tamper event this cycle
	logic                ts_trigger;   // timestamp capture request
	logic [BKP_W-1:0]    bkp_mem [BKP_WORDS]; // backup word file
	logic [SAMP_W-1:0]   samp_cnt;     // cycles to the next sample
	logic [SAMP_W-1:0]   samp_period;  // period from the rate field
	logic [SAMP_W-1:0]   prch_len;     // precharge cycles: 1, 2, 4 or 8
	logic                samp_tick;    // sample strobe to the channels
	logic                prch_win;     // precharge window open
	logic [6:0]          apre_cnt;     // async prescaler counter
	logic [7:0]          spre_cnt;     // sync prescaler low byte counter
	logic                apre_wrap;    // async counter wraps
	logic                cal_wave;     // selected calibration waveform
	logic                sel_flag;     // alarm flag picked by select
	logic                alarm_lvl;    // alarm level after polarity
	logic [2:0]          alarm_prev;   // last alarm a, b, wakeup flags
	logic                alarm_rise;   // an alarm or wakeup flag rose
	logic                next_pin;     // next shared pin value
	logic                next_oe;      // next shared pin enable

	// the small variant keeps only the first input, edge only
	assign filt_eff = single_input_variant_in ? FILT_EDGE : tamper_filter_count_in; // [RULE1]

	// one channel per tamper input
	genvar g;
	generate
		for (g = 0; g < NUM_TAMP; g++)
		begin : g_chan
			rta_chan_if chif ();
			assign chan_en[g] = tamper_input_enable_in[g] & (g == 0 || !single_input_variant_in); // [RULE1]
			assign chif.enable = chan_en[g]; // [RULE4]
			assign chif.trigger = tamper_trigger_polarity_in[g];
			assign chif.filt = filt_eff;
			assign chif.sample_tick = samp_tick;
			assign tamp_event[g] = chif.event_p;
			rta_tamper_chan u_chan (
				.clk_in    (clk_in),
				.rst_n_in  (rst_n_in),
				.clk_en_in (clk_en_in),
				.pin_in    (tamper_pin_in[g]),
				.ch        (chif.chan)
			);
		end
	endgenerate

	assign any_event = |tamp_event;
	assign ts_trigger = (timestamp_on_tamper_in & any_event) | timestamp_event_in; // [RULE6]

	// tamper flags: a new event beats a clear in the same cycle
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			tamper_flag_out <= '0;
		else if (clk_en_in)
			tamper_flag_out <= (tamper_flag_out & ~tamper_flag_clear_in) | tamp_event; // [RULE4]
	end

	// interrupt follows pending flags while enabled
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			tamper_irq_out <= 1'b0;
		else if (clk_en_in)
			tamper_irq_out <= tamper_irq_enable_in & (|tamper_flag_out | any_event); // [RULE5]
	end

	// timestamp flags, set beside the tamper flag
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			timestamp_flag_out <= 1'b0;
			timestamp_overflow_flag_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			// a capture while the flag stands is an overflow
			if (ts_trigger && timestamp_flag_out)
				timestamp_overflow_flag_out <= 1'b1; // [RULE6]
			else if (timestamp_flag_clear_in)
				timestamp_overflow_flag_out <= 1'b0;
			if (ts_trigger)
				timestamp_flag_out <= 1'b1; // [RULE6]
			else if (timestamp_flag_clear_in)
				timestamp_flag_out <= 1'b0;
		end
	end

	// backup words: only power-on reset or tamper wipes them
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < BKP_WORDS; i++)
				bkp_mem[i] <= '0; // [RULE2]
		end
		else if (clk_en_in)
		begin
			// wipe wins over a write in the same cycle
			if (any_event)
			begin
				for (int i = 0; i < BKP_WORDS; i++)
					bkp_mem[i] <= '0; // [RULE3]
			end
			else if (bkp_wr_en_in)
				bkp_mem[bkp_addr_in] <= bkp_wdata_in; // [RULE2]
		end
	end

	// registered read port
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			bkp_rdata_out <= '0;
		else if (clk_en_in)
			bkp_rdata_out <= bkp_mem[bkp_addr_in];
	end

	// sample timer: faster rate means more pull-up current
	assign samp_period = SAMP_SLOW >> tamper_sample_rate_in; // [RULE12]
	assign prch_len = PRCH_ONE << tamper_precharge_duration_in;
	assign samp_tick = (samp_cnt == '0);
	assign prch_win = (samp_cnt <= prch_len);

	// count down to each sample, reload on it
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			samp_cnt <= '0;
		else if (clk_en_in)
		begin
			if (samp_tick)
				samp_cnt <= samp_period - PRCH_ONE; // [RULE12]
			else
				samp_cnt <= samp_cnt - PRCH_ONE;
		end
	end

	// pull-up only in filtered mode, ending the cycle after the sample cycle
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			tamper_pullup_out <= '0;
		else if (clk_en_in)
		begin
			if (filt_eff != FILT_EDGE && !tamper_pullup_disable_in && prch_win)
				tamper_pullup_out <= chan_en; // [RULE11]
			else
				tamper_pullup_out <= '0;
		end
	end

	// prescaler chain; no smooth calibration input reaches it
	assign apre_wrap = (apre_cnt >= async_prescaler_in); // [RULE14]

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			apre_cnt <= '0;
			spre_cnt <= '0;
		end
		else if (clk_en_in)
		begin
			apre_cnt <= apre_wrap ? 7'h00 : apre_cnt + 7'h01; // [RULE13]
			// a pending shift stalls this stage, so the slow output jitters
			if (apre_wrap && !shift_pending_flag_in) // [RULE16]
				spre_cnt <= (spre_cnt >= sync_prescaler_low_in) ? 8'h00 : spre_cnt + 8'h01;
		end
	end

	// select picks the fast tap or the slow stage
	always_comb
	begin
		if (cal_output_select_in)
			cal_wave = spre_cnt[CAL_SYNC_TAP]; // [RULE15]
		else
			cal_wave = apre_cnt[CAL_ASYNC_TAP]; // [RULE13]
	end

	// alarm flag mux, zero means no alarm output
	always_comb
	begin
		case (alarm_output_select_in)
			ALARM_OUTPUT_SELECT_ALRA: sel_flag = alarm_a_flag_in; // [RULE17]
			ALARM_OUTPUT_SELECT_ALRB: sel_flag = alarm_b_flag_in;
			ALARM_OUTPUT_SELECT_WKUP: sel_flag = wakeup_timer_flag_in;
			default:   sel_flag = 1'b0;
		endcase
	end

	assign alarm_lvl = sel_flag ^ alarm_output_polarity_in; // [RULE18]

	// shared pin: calibration first, then alarm, else released
	always_comb
	begin
		next_pin = 1'b0;
		next_oe = 1'b0;
		if (cal_output_enable_in)
		begin
			next_pin = cal_wave; // [RULE20]
			next_oe = 1'b1;
		end
		else if (alarm_output_select_in != ALARM_OUTPUT_SELECT_OFF)
		begin
			// open drain only ever pulls low
			if (alarm_output_drive_type_in == DRIVE_OD)
				next_oe = ~alarm_lvl; // [RULE19]
			else
			begin
				next_pin = alarm_lvl;
				next_oe = 1'b1; // [RULE20]
			end
		end
	end

	// pin registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			shared_function_pin_out <= 1'b0;
			shared_function_pin_oe_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			shared_function_pin_out <= next_pin;
			shared_function_pin_oe_out <= next_oe;
		end
	end

	assign alarm_rise = |({alarm_a_flag_in, alarm_b_flag_in, wakeup_timer_flag_in} & ~alarm_prev);

	// wake request from any event while on a slow oscillator
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			alarm_prev <= '0;
			low_power_exit_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			alarm_prev <= {alarm_a_flag_in, alarm_b_flag_in, wakeup_timer_flag_in};
			low_power_exit_out <= low_speed_clock_source_in &
				(any_event | ts_trigger | alarm_rise); // [RULE22]
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_FLAG_SET: assert property ( // [RULE4]
		clk_en_in && tamp_event[0] |=> tamper_flag_out[0])
		else $error("tamper flag not set by event");
	AST_BKP_WIPE: assert property ( // [RULE3]
		clk_en_in && any_event |=> bkp_mem[0] == '0 && bkp_mem[BKP_WORDS-1] == '0)
		else $error("backup words not wiped");
	AST_IRQ: assert property ( // [RULE5]
		clk_en_in && tamper_irq_enable_in && any_event |=> tamper_irq_out)
		else $error("tamper interrupt missing");
	AST_TS_TAMP: assert property ( // [RULE6]
		clk_en_in && timestamp_on_tamper_in && tamp_event[0]
		|=> timestamp_flag_out && tamper_flag_out[0])
		else $error("timestamp and tamper flag not set together");
	AST_PU_OFF: assert property ( // [RULE11]
		clk_en_in && (tamper_pullup_disable_in || filt_eff == FILT_EDGE) |=> tamper_pullup_out == '0)
		else $error("pull-up on when not allowed");
	AST_CAL_OE: assert property ( // [RULE20]
		clk_en_in && cal_output_enable_in |=> shared_function_pin_oe_out)
		else $error("calibration did not force output");
	AST_ALARM_PP: assert property ( // [RULE18]
		clk_en_in && !cal_output_enable_in && alarm_output_select_in != ALARM_OUTPUT_SELECT_OFF
		&& alarm_output_drive_type_in != DRIVE_OD
		|=> shared_function_pin_oe_out && shared_function_pin_out == $past(alarm_lvl))
		else $error("alarm push-pull level wrong");
	AST_ALARM_OD: assert property ( // [RULE19]
		clk_en_in && !cal_output_enable_in && alarm_output_drive_type_in == DRIVE_OD
		|=> !shared_function_pin_out)
		else $error("open drain drove high");
	AST_LP_EXIT: assert property ( // [RULE22]
		clk_en_in && low_speed_clock_source_in && any_event |=> low_power_exit_out)
		else $error("no low-power exit on tamper");
	AST_SAMPLE_GAP: assert property ( // [RULE12]
		clk_en_in && samp_tick && tamper_sample_rate_in == 3'h7 ##1 clk_en_in
		|-> !samp_tick)
		else $error("sample ticks back to back");
	COV_TAMP_TS: cover property (timestamp_on_tamper_in && any_event);
	COV_OVF: cover property (timestamp_overflow_flag_out);
	COV_ALARM: cover property (alarm_output_select_in != ALARM_OUTPUT_SELECT_OFF && shared_function_pin_oe_out);
endmodule

// ===== rta_tamper_switch.sv
// tamper switch and pin model standing outside the tamper pins
`timescale 1ns/1ns
module rta_tamper_switch
	import rta_pkg::*;
(
	input  wire logic                clk_in,
	input  wire logic [NUM_TAMP-1:0] sw_ground_in,
	input  wire logic [NUM_TAMP-1:0] sw_high_in,
	input  wire logic [NUM_TAMP-1:0] pullup_in,
	output logic      [NUM_TAMP-1:0] pin_out
);
	logic [NUM_TAMP-1:0] float_q = '0; // level of an open, unpulled pin

	// an open pin with nothing holding it wanders every cycle, never kind
	always @(posedge clk_in)
		float_q <= ~float_q;

	// ground wins, then tie high, then the device pull-up
	always_comb
	begin
		for (int i = 0; i < NUM_TAMP; i++)
			pin_out[i] = sw_ground_in[i] ? 1'b0 : (sw_high_in[i] | pullup_in[i] | float_q[i]);
	end
endmodule

// ===== test_rtc_tamper_backup_aux_outputs.sv
// self-checking bench for the tamper, backup and auxiliary output block
`timescale 1ns/1ns
module test_rtc_tamper_backup_aux_outputs;
	import rta_pkg::*;
	logic clk_in, rst_n_in, clk_en_in, single_input_variant_in, tamper_pullup_disable_in;
	logic tamper_irq_enable_in, timestamp_on_tamper_in, timestamp_event_in;
	logic timestamp_flag_clear_in, bkp_wr_en_in, cal_output_enable_in, cal_output_select_in;
	logic shift_pending_flag_in, alarm_output_polarity_in, alarm_output_drive_type_in;
	logic alarm_a_flag_in, alarm_b_flag_in, wakeup_timer_flag_in, low_speed_clock_source_in;
	logic [NUM_TAMP-1:0] tamper_pin_in, tamper_input_enable_in, tamper_trigger_polarity_in;
	logic [NUM_TAMP-1:0] tamper_flag_clear_in, tamper_flag_out, tamper_pullup_out;
	logic [NUM_TAMP-1:0] sw_ground, sw_high;  // switch positions per channel
	logic [1:0] tamper_filter_count_in, tamper_precharge_duration_in, alarm_output_select_in;
	logic [2:0]          tamper_sample_rate_in;
	logic [BKP_AW-1:0]   bkp_addr_in;
	logic [BKP_W-1:0]    bkp_wdata_in, bkp_rdata_out;
	logic [6:0]          async_prescaler_in;
	logic [7:0]          sync_prescaler_low_in;
	logic tamper_irq_out, timestamp_flag_out, timestamp_overflow_flag_out;
	logic shared_function_pin_out, shared_function_pin_oe_out, low_power_exit_out;
	logic seen_lpe, seen_pu;  // pulses seen during a flag wait
	int num_errors = 0;
	int n_tests = 0;

	rta_top u_dut (.*);
	rta_tamper_switch u_sw (.clk_in(clk_in), .sw_ground_in(sw_ground), .sw_high_in(sw_high),
		.pullup_in(tamper_pullup_out), .pin_out(tamper_pin_in));

	// 50 MHz kernel clock
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// overall run limit, a hang ends in the report
	initial
	begin
		#2000000;
		num_errors++;
		$display("MISMATCH t=%0t run limit reached", $time);
		conclude;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// inputs only ever move at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// bounded wait for one tamper flag, noting pulses on the way
	task automatic wait_flag(input int idx, input int bound);
		int k;
		for (k = 0; k < bound; k++)
		begin
			seen_lpe |= (low_power_exit_out === 1'b1);
			seen_pu |= (tamper_pullup_out[idx] === 1'b1);
			if (tamper_flag_out[idx] === 1'b1)
				break;
			cyc(1);
		end
		if (k >= bound)
		begin
			num_errors++;
			$display("MISMATCH t=%0t tamper flag never rose", $time);
			conclude;
		end
	endtask

	// one write strobe, then an idle edge so calls can follow back to back
	task automatic bkp_wr(input logic [BKP_AW-1:0] a, input logic [BKP_W-1:0] d);
		bkp_addr_in = a;
		bkp_wdata_in = d;
		bkp_wr_en_in = 1'b1;
		cyc(1);
		bkp_wr_en_in = 1'b0;
		cyc(1);
	endtask

	task automatic bkp_rd(input logic [BKP_AW-1:0] a, input logic [BKP_W-1:0] exp);
		bkp_addr_in = a;
		cyc(2);
		chk(bkp_rdata_out, exp);
	endtask

	// clear tamper flags, and the timestamp flags when asked
	task automatic clr(input logic ts);
		tamper_flag_clear_in = '1;
		timestamp_flag_clear_in = ts;
		cyc(1);
		tamper_flag_clear_in = '0;
		timestamp_flag_clear_in = 1'b0;
		cyc(1);
	endtask

	// cycles between two rising edges on the shared pin
	task automatic cal_period(input int exp);
		int k, t0;
		logic prev;
		t0 = -1;
		prev = shared_function_pin_out;
		for (k = 0; k < 2000; k++)
		begin
			cyc(1);
			if (shared_function_pin_out === 1'b1 && prev === 1'b0)
			begin
				if (t0 >= 0)
					break;
				t0 = k;
			end
			prev = shared_function_pin_out;
		end
		chk(k - t0, exp);
		if (k >= 2000)
		begin
			num_errors++;
			$display("MISMATCH t=%0t no calibration edges", $time);
			conclude;
		end
	endtask

	// main sequence
	initial
	begin
		int s, p, ty;
		logic v;
		{single_input_variant_in, tamper_pullup_disable_in, timestamp_event_in} = '0;
		{timestamp_flag_clear_in, bkp_wr_en_in, cal_output_enable_in, cal_output_select_in} = '0;
		{shift_pending_flag_in, alarm_output_polarity_in, alarm_output_drive_type_in} = '0;
		{alarm_a_flag_in, alarm_b_flag_in, wakeup_timer_flag_in} = '0;
		{tamper_input_enable_in, tamper_trigger_polarity_in, tamper_flag_clear_in} = '0;
		{tamper_filter_count_in, tamper_precharge_duration_in, alarm_output_select_in} = '0;
		{bkp_addr_in, bkp_wdata_in, async_prescaler_in, sync_prescaler_low_in} = '0;
		tamper_sample_rate_in = 3'h7;
		tamper_irq_enable_in = 1'b1;
		timestamp_on_tamper_in = 1'b1;
		low_speed_clock_source_in = 1'b1;
		clk_en_in = 1'b1;
		sw_ground = '1;
		sw_high = '0;
		rst_n_in = 1'b0;
		cyc(8);
		rst_n_in = 1'b1;
		cyc(1);
		bkp_rd(5'h1f, 32'h0);
		chk(tamper_flag_out, 32'h0);
		// rising edge on channel 0 clears the backup words
		bkp_wr(5'h00, 32'ha5a5_0f0f);
		bkp_wr(5'h1f, 32'h1234_5678);
		bkp_rd(5'h00, 32'ha5a5_0f0f);
		bkp_rd(5'h1f, 32'h1234_5678);
		tamper_input_enable_in = 3'h1;
		cyc(4);
		chk(tamper_flag_out, 32'h0);
		{seen_lpe, seen_pu} = '0;
		sw_ground[0] = 1'b0;
		sw_high[0] = 1'b1;
		wait_flag(0, 20);
		chk(timestamp_flag_out, 32'h1);
		chk(tamper_irq_out, 32'h1);
		chk(seen_lpe, 32'h1);
		chk(seen_pu, 32'h0);
		bkp_rd(5'h00, 32'h0);
		bkp_rd(5'h1f, 32'h0);
		// pin grounded again, flag cleared, input cycled before rewriting
		sw_ground[0] = 1'b1;
		sw_high[0] = 1'b0;
		clr(1'b0);
		tamper_input_enable_in = 3'h0;
		cyc(2);
		tamper_input_enable_in = 3'h1;
		cyc(6);
		bkp_wr(5'h05, 32'hdead_0001);
		bkp_rd(5'h05, 32'hdead_0001);
		$display("test edge done");
		// channel 1 already low when enabled, channel 2 high but disabled
		sw_ground = 3'h3;
		sw_high = 3'h4;
		tamper_trigger_polarity_in = 3'h2;
		tamper_input_enable_in = 3'h3;
		wait_flag(1, 20);
		chk(timestamp_overflow_flag_out, 32'h1);
		cyc(6);
		chk(tamper_flag_out, 32'h2);
		// small variant ignores channel 2
		clr(1'b1);
		tamper_input_enable_in = 3'h0;
		single_input_variant_in = 1'b1;
		cyc(2);
		tamper_input_enable_in = 3'h4;
		cyc(10);
		chk(tamper_flag_out, 32'h0);
		chk(tamper_irq_out, 32'h0);
		tamper_input_enable_in = 3'h0;
		single_input_variant_in = 1'b0;
		$display("test enable and variant done");
		// filtered level, two samples, pull-up on
		sw_ground = 3'h7;
		sw_high = 3'h0;
		tamper_trigger_polarity_in = 3'h4;
		tamper_filter_count_in = 2'h1;
		cyc(2);
		clr(1'b1);
		seen_pu = 1'b0;
		tamper_input_enable_in = 3'h4;
		wait_flag(2, 60);
		chk(seen_pu, 32'h1);
		// eight samples, pull-up disabled
		tamper_input_enable_in = 3'h0;
		tamper_pullup_disable_in = 1'b1;
		tamper_filter_count_in = 2'h3;
		clr(1'b1);
		seen_pu = 1'b0;
		tamper_input_enable_in = 3'h4;
		cyc(12);
		chk(tamper_flag_out, 32'h0);
		wait_flag(2, 80);
		chk(seen_pu, 32'h0);
		// slowest sample rate needs a full sample period
		tamper_input_enable_in = 3'h0;
		tamper_pullup_disable_in = 1'b0;
		tamper_filter_count_in = 2'h1;
		tamper_sample_rate_in = 3'h0;
		clr(1'b1);
		tamper_input_enable_in = 3'h4;
		cyc(250);
		chk(tamper_flag_out, 32'h0);
		wait_flag(2, 600);
		tamper_input_enable_in = 3'h0;
		tamper_filter_count_in = 2'h0;
		clr(1'b1);
		$display("test filtered done");
		// calibration clock on the shared pin
		cal_output_enable_in = 1'b1;
		async_prescaler_in = 7'h7f;
		cyc(3);
		chk(shared_function_pin_oe_out, 32'h1);
		cal_period(64);
		// clock enable low must freeze the shared pin
		clk_en_in = 1'b0;
		v = shared_function_pin_out;
		cyc(40);
		chk(shared_function_pin_out, {31'h0, v});
		clk_en_in = 1'b1;
		cal_output_select_in = 1'b1;
		async_prescaler_in = 7'h01;
		sync_prescaler_low_in = 8'hff;
		cal_period(512);
		cal_output_enable_in = 1'b0;
		$display("test calibration done");
		// alarm output over every select, polarity and drive type
		alarm_a_flag_in = 1'b1;
		wakeup_timer_flag_in = 1'b1;
		for (s = 0; s < 4; s++)
			for (p = 0; p < 2; p++)
				for (ty = 0; ty < 2; ty++)
				begin
					alarm_output_select_in = s[1:0];
					alarm_output_polarity_in = p[0];
					alarm_output_drive_type_in = ty[0];
					cyc(3);
					v = ((s == 2) ? 1'b0 : 1'b1) ^ p[0];
					if (s == 0)
						chk(shared_function_pin_oe_out, 32'h0);
					else if (ty == 1)
					begin
						chk(shared_function_pin_oe_out, 32'h1);
						chk(shared_function_pin_out, {31'h0, v});
					end
					else
					begin
						chk(shared_function_pin_out, 32'h0);
						chk(shared_function_pin_oe_out, {31'h0, ~v});
					end
				end
		$display("test alarm output done");
		conclude;
	end
endmodule
